//--- logic/cpu_core_params.svh
`ifndef CPU_CORE_PARAMS_SVH
`define CPU_CORE_PARAMS_SVH
// data-space locations of the core registers
`define ADDR_PTR_ONE 8'h80
`define ADDR_PTR_TWO 8'h81
`define ADDR_SD_ONE 8'h82
`define ADDR_SD_TWO 8'h83
`define ADDR_ACC 8'hff
// byte reset value and zero compare value
`define BYTE_RESET 8'h00
`define BYTE_ZERO 8'h00
// program counter load values
`define PC_RESET_VEC 12'hffe
`define PC_NMI_VEC 12'hffc
`define PC_STEP 12'h001
// return stack geometry
`define STACK_LEVELS 6
`define STACK_FULL 3'h6
`define STACK_EMPTY 3'h0
`define STACK_STEP 3'h1
`endif

//--- logic/cpu_core_pkg.sv
`include "cpu_core_params.svh"

package cpu_core_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [11:0] pc_t;
   typedef logic [2:0] depth_t;

   // program counter load source requested by the sequencer
   typedef enum logic [3:0] {
      PC_HOLD, PC_INC, PC_JUMP, PC_CALL, PC_REL, PC_IRQ, PC_NMI, PC_RET, PC_INTERRUPT_RETURN_INSTR
   } pc_op_e;

   // flag context in use
   typedef enum logic [1:0] {CTX_NORMAL, CTX_IRQ, CTX_NMI} ctx_e;

   // next sequential program address
   function automatic pc_t pc_step(pc_t base);
      return base + `PC_STEP;
   endfunction

   // program address plus a signed byte offset
   function automatic pc_t pc_add(pc_t base, byte_t offset);
      return base + {{4{offset[7]}}, offset};
   endfunction
endpackage

//--- logic/return_stack.sv
`include "cpu_core_params.svh"

module return_stack
   import cpu_core_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic push,
   input wire logic pop,
   input wire pc_t push_value,
   output pc_t top,
   output depth_t depth
);
   typedef struct packed {
      pc_t [`STACK_LEVELS-1:0] level;
      depth_t depth;
   } stack_s;

   stack_s st;
   stack_s next_st;

   // shift levels down on push, up on pop; depth saturates at both ends
   always_comb begin
      next_st = st;
      if (push) begin
         for (int i = `STACK_LEVELS - 1; i > 0; i--) begin
            next_st.level[i] = st.level[i-1];
         end
         next_st.level[0] = push_value;
         if (st.depth != `STACK_FULL) begin
            next_st.depth = st.depth + `STACK_STEP;
         end
      end else if (pop && st.depth != `STACK_EMPTY) begin
         for (int i = 0; i < `STACK_LEVELS - 1; i++) begin
            next_st.level[i] = st.level[i+1];
         end
         next_st.depth = st.depth - `STACK_STEP;
      end
   end

   // six 12-bit levels held apart from data space
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign top = st.level[0];
   assign depth = st.depth;
endmodule

//--- logic/flag_bank.sv
`include "cpu_core_params.svh"

module flag_bank
   import cpu_core_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic enter_irq,
   input wire logic enter_nmi,
   input wire logic leave,
   input wire logic c_we,
   input wire logic c_in,
   input wire logic z_we,
   input wire logic z_in,
   output ctx_e ctx,
   output logic carry,
   output logic zero
);
   typedef struct packed {
      logic normal_carry_flag;
      logic normal_zero_flag;
      logic irq_carry_flag;
      logic irq_zero_flag;
      logic nmi_carry_flag;
      logic nmi_zero_flag;
      ctx_e ctx;
      ctx_e prior_one;
      ctx_e prior_two;
      logic carry;
      logic zero;
   } flags_s;

   flags_s st;
   flags_s next_st;

   always_comb begin
      next_st = st;
      // only the pair of the running context takes updates
      unique case (st.ctx)
         CTX_NORMAL: begin
            if (c_we) next_st.normal_carry_flag = c_in;
            if (z_we) next_st.normal_zero_flag = z_in;
         end
         CTX_IRQ: begin
            if (c_we) next_st.irq_carry_flag = c_in;
            if (z_we) next_st.irq_zero_flag = z_in;
         end
         CTX_NMI: begin
            if (c_we) next_st.nmi_carry_flag = c_in;
            if (z_we) next_st.nmi_zero_flag = z_in;
         end
         default: next_st.ctx = CTX_NMI;
      endcase
      // context switch keeps two levels of history, no flag is cleared
      if (enter_irq || enter_nmi) begin
         next_st.prior_two = st.prior_one;
         next_st.prior_one = st.ctx;
         next_st.ctx = enter_nmi ? CTX_NMI : CTX_IRQ;
      end else if (leave) begin
         next_st.ctx = st.prior_one;
         next_st.prior_one = st.prior_two;
         next_st.prior_two = CTX_NORMAL;
      end
      // registered view of the pair that will be in use
      unique case (next_st.ctx)
         CTX_NORMAL: begin
            next_st.carry = next_st.normal_carry_flag;
            next_st.zero = next_st.normal_zero_flag;
         end
         CTX_IRQ: begin
            next_st.carry = next_st.irq_carry_flag;
            next_st.zero = next_st.irq_zero_flag;
         end
         default: begin
            next_st.carry = next_st.nmi_carry_flag;
            next_st.zero = next_st.nmi_zero_flag;
         end
      endcase
   end

   // reset lands in the nmi context
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.ctx <= CTX_NMI;
      end else begin
         st <= next_st;
      end
   end

   assign ctx = st.ctx;
   assign carry = st.carry;
   assign zero = st.zero;
endmodule

//--- logic/cpu_core_regs_flags_stack.sv
`include "cpu_core_params.svh"

module cpu_core_regs_flags_stack
   import cpu_core_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire byte_t ds_addr,
   input wire logic ds_rd,
   input wire logic ds_wr,
   input wire byte_t ds_wdata,
   output byte_t ds_rdata,
   output logic ds_hit,
   input wire logic alu_acc_we,
   input wire byte_t alu_acc_data,
   input wire pc_op_e pc_op,
   input wire pc_t jump_target,
   input wire byte_t rel_offset,
   input wire pc_t irq_vector,
   input wire logic flag_c_we,
   input wire logic flag_c_in,
   input wire logic flag_z_we,
   input wire byte_t alu_result,
   output byte_t accumulator,
   output byte_t pointer_reg_one,
   output byte_t pointer_reg_two,
   output byte_t short_direct_reg_one,
   output byte_t short_direct_reg_two,
   output pc_t pc,
   output logic carry_flag,
   output logic zero_flag,
   output ctx_e flag_context
);
   typedef struct packed {
      byte_t accumulator;
      byte_t pointer_reg_one;
      byte_t pointer_reg_two;
      byte_t short_direct_reg_one;
      byte_t short_direct_reg_two;
      pc_t pc;
      byte_t ds_rdata;
      logic ds_hit;
   } core_s;

   core_s st;
   core_s next_st;
   pc_t stack_top;
   depth_t stack_depth;
   logic push;
   logic pop;
   logic stack_empty;

   // true for the five data-space locations this block answers
   function automatic logic mapped(byte_t addr);
      return addr == `ADDR_ACC || addr == `ADDR_PTR_ONE || addr == `ADDR_PTR_TWO
         || addr == `ADDR_SD_ONE || addr == `ADDR_SD_TWO;
   endfunction

   // stack moves with calls, interrupts and both returns
   assign push = pc_op inside {PC_CALL, PC_IRQ, PC_NMI};
   assign pop = pc_op inside {PC_RET, PC_INTERRUPT_RETURN_INSTR};
   assign stack_empty = stack_depth == `STACK_EMPTY;

   return_stack u_stack (
      .mclk(mclk),
      .resetn(resetn),
      .push(push),
      .pop(pop),
      .push_value(st.pc),
      .top(stack_top),
      .depth(stack_depth)
   );

   // carry straight from the alu, zero derived from its result
   flag_bank u_flags (
      .mclk(mclk),
      .resetn(resetn),
      .enter_irq(pc_op == PC_IRQ),
      .enter_nmi(pc_op == PC_NMI),
      .leave(pc_op == PC_INTERRUPT_RETURN_INSTR),
      .c_we(flag_c_we),
      .c_in(flag_c_in),
      .z_we(flag_z_we),
      .z_in(alu_result == `BYTE_ZERO),
      .ctx(flag_context),
      .carry(carry_flag),
      .zero(zero_flag)
   );

   always_comb begin
      next_st = st;
      // registered read port, unmapped addresses read zero with no hit
      next_st.ds_hit = 1'b0;
      next_st.ds_rdata = `BYTE_ZERO;
      if (ds_rd) begin
         next_st.ds_hit = mapped(ds_addr);
         case (ds_addr)
            `ADDR_ACC: next_st.ds_rdata = st.accumulator;
            `ADDR_PTR_ONE: next_st.ds_rdata = st.pointer_reg_one;
            `ADDR_PTR_TWO: next_st.ds_rdata = st.pointer_reg_two;
            `ADDR_SD_ONE: next_st.ds_rdata = st.short_direct_reg_one;
            `ADDR_SD_TWO: next_st.ds_rdata = st.short_direct_reg_two;
            default: next_st.ds_rdata = `BYTE_ZERO;
         endcase
      end
      // alu result first, a data-space write to the accumulator in the same cycle wins
      if (alu_acc_we) begin
         next_st.accumulator = alu_acc_data;
      end
      if (ds_wr) begin
         case (ds_addr)
            `ADDR_ACC: next_st.accumulator = ds_wdata;
            `ADDR_PTR_ONE: next_st.pointer_reg_one = ds_wdata;
            `ADDR_PTR_TWO: next_st.pointer_reg_two = ds_wdata;
            `ADDR_SD_ONE: next_st.short_direct_reg_one = ds_wdata;
            `ADDR_SD_TWO: next_st.short_direct_reg_two = ds_wdata;
            default: next_st.accumulator = next_st.accumulator;
         endcase
      end
      // program counter load sources
      unique case (pc_op)
         PC_HOLD: next_st.pc = st.pc;
         PC_INC: next_st.pc = pc_step(st.pc);
         PC_JUMP, PC_CALL: next_st.pc = jump_target;
         PC_REL: next_st.pc = pc_add(st.pc, rel_offset);
         PC_IRQ: next_st.pc = irq_vector;
         PC_NMI: next_st.pc = `PC_NMI_VEC;
         PC_RET, PC_INTERRUPT_RETURN_INSTR: begin
            next_st.pc = stack_empty ? pc_step(st.pc) : stack_top;
         end
         default: next_st.pc = st.pc;
      endcase
   end

   // twelve-bit counter starts at the reset vector
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.pc <= `PC_RESET_VEC;
      end else begin
         st <= next_st;
      end
   end

   assign accumulator = st.accumulator;
   assign pointer_reg_one = st.pointer_reg_one;
   assign pointer_reg_two = st.pointer_reg_two;
   assign short_direct_reg_one = st.short_direct_reg_one;
   assign short_direct_reg_two = st.short_direct_reg_two;
   assign pc = st.pc;
   assign ds_rdata = st.ds_rdata;
   assign ds_hit = st.ds_hit;

   // checks on the behaviour above
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   sequence s_bus_wr(byte_t a);
      ds_wr && ds_addr == a;
   endsequence
   sequence s_call;
      pc_op == PC_CALL;
   endsequence
   sequence s_irq_quiet;
      pc_op == PC_IRQ && !flag_c_we;
   endsequence
   sequence s_interrupt_return_instr_quiet;
      pc_op == PC_INTERRUPT_RETURN_INSTR && !flag_c_we;
   endsequence

   AST_ACC_MAP: assert property (
      s_bus_wr(`ADDR_ACC) |=> accumulator == $past(ds_wdata))
      else $error("accumulator missed a data-space write");

   AST_PTR_READ: assert property (
      ds_rd && ds_addr == `ADDR_PTR_TWO |=> ds_hit && ds_rdata == $past(pointer_reg_two))
      else $error("second pointer read back wrong");

   AST_SD_ROUND: assert property (
      s_bus_wr(`ADDR_SD_ONE) ##1 (ds_rd && !ds_wr && ds_addr == `ADDR_SD_ONE)
      |=> ds_rdata == $past(ds_wdata, 2))
      else $error("short-direct byte did not read back its write");

   AST_PC_INC: assert property (
      pc_op == PC_INC |=> pc == $past(pc) + `PC_STEP)
      else $error("program counter did not step by one");

   AST_PC_REL: assert property (
      pc_op == PC_REL |=> pc == pc_add($past(pc), $past(rel_offset)))
      else $error("relative branch landed wrong");

   AST_CALL: assert property (
      s_call |=> pc == $past(jump_target) && stack_top == $past(pc))
      else $error("call did not load target and push return");

   AST_CALL_RET: assert property (
      s_call ##1 pc_op == PC_RET |=> pc == $past(pc, 2))
      else $error("return did not come back to caller");

   AST_RET_EMPTY: assert property (
      pop && stack_empty |=> pc == $past(pc) + `PC_STEP && stack_empty)
      else $error("return on empty stack misbehaved");

   AST_STACK_SAT: assert property (
      push && stack_depth == `STACK_FULL |=> stack_depth == `STACK_FULL)
      else $error("stack depth left its deepest position");

   AST_RESET_CTX: assert property (
      $rose(resetn) |-> flag_context == CTX_NMI)
      else $error("reset did not start in nmi context");

   AST_NEST_CTX: assert property (
      pc_op == PC_IRQ ##1 pc_op == PC_NMI ##1 pc_op == PC_INTERRUPT_RETURN_INSTR |=> flag_context == CTX_IRQ)
      else $error("nested nmi returned to wrong context");

   AST_FLAG_KEEP: assert property (
      s_irq_quiet ##1 s_interrupt_return_instr_quiet |=> carry_flag == $past(carry_flag, 2))
      else $error("carry not kept across interrupt and return");

   AST_ZERO: assert property (
      flag_z_we && pc_op == PC_INC |=> zero_flag == ($past(alu_result) == `BYTE_ZERO))
      else $error("zero flag does not match result");

   AST_CARRY: assert property (
      flag_c_we && pc_op == PC_HOLD |=> carry_flag == $past(flag_c_in))
      else $error("carry flag did not take alu carry");

   // register map, read port, counter sources and stack movement
   AST_PTR_ONE_MAP: assert property (
      s_bus_wr(`ADDR_PTR_ONE) |=> pointer_reg_one == $past(ds_wdata))
      else $error("first pointer missed a data-space write");

   AST_SD_TWO_MAP: assert property (
      s_bus_wr(`ADDR_SD_TWO) |=> short_direct_reg_two == $past(ds_wdata))
      else $error("second short-direct byte missed a data-space write");

   AST_ACC_READ: assert property (
      ds_rd && ds_addr == `ADDR_ACC |=> ds_hit && ds_rdata == $past(accumulator))
      else $error("accumulator read back wrong");

   AST_WR_RD_SAME: assert property (
      ds_rd && ds_wr && ds_addr == `ADDR_SD_ONE
      |=> ds_rdata == $past(short_direct_reg_one) && short_direct_reg_one == $past(ds_wdata))
      else $error("read beside a write did not return the old byte");

   AST_UNMAPPED: assert property (
      ds_rd && !mapped(ds_addr) |=> !ds_hit && ds_rdata == `BYTE_ZERO)
      else $error("unmapped read answered");

   AST_RD_IDLE: assert property (
      !ds_rd |=> !ds_hit && ds_rdata == `BYTE_ZERO)
      else $error("read port not idle without a read");

   AST_ALU_ACC: assert property (
      alu_acc_we && !ds_wr |=> accumulator == $past(alu_acc_data))
      else $error("accumulator missed an alu write");

   AST_JUMP: assert property (
      pc_op == PC_JUMP |=> pc == $past(jump_target))
      else $error("jump did not load its target");

   AST_HOLD: assert property (
      pc_op == PC_HOLD |=> pc == $past(pc))
      else $error("program counter moved while held");

   AST_IRQ_VEC: assert property (
      pc_op == PC_IRQ |=> pc == $past(irq_vector) && flag_context == CTX_IRQ)
      else $error("interrupt entry missed vector or context");

   AST_NMI_VEC: assert property (
      pc_op == PC_NMI |=> pc == `PC_NMI_VEC && flag_context == CTX_NMI)
      else $error("nmi entry missed vector or context");

   AST_PUSH_DEPTH: assert property (
      push && stack_depth != `STACK_FULL
      |=> stack_depth == $past(stack_depth) + `STACK_STEP && stack_top == $past(pc))
      else $error("push did not deepen the stack with the counter");

   AST_PUSH_FULL: assert property (
      push && stack_depth == `STACK_FULL |=> stack_top == $past(pc))
      else $error("push on a full stack lost the newest address");

   AST_RET_POP: assert property (
      pop && !stack_empty
      |=> pc == $past(stack_top) && stack_depth == $past(stack_depth) - `STACK_STEP)
      else $error("return did not pop the top level");

   AST_RET_CTX: assert property (
      pc_op == PC_RET |=> flag_context == $past(flag_context))
      else $error("subroutine return changed the flag context");
endmodule

//--- verification/sequencer_model.sv
// sequencer and data-space master facing the core registers
module sequencer_model
   import cpu_core_pkg::*;
(
   input wire logic mclk,
   output byte_t ds_addr,
   output logic ds_rd,
   output logic ds_wr,
   output byte_t ds_wdata,
   output logic alu_acc_we,
   output byte_t alu_acc_data,
   output pc_op_e pc_op,
   output pc_t jump_target,
   output byte_t rel_offset,
   output pc_t irq_vector,
   output logic flag_c_we,
   output logic flag_c_in,
   output logic flag_z_we,
   output byte_t alu_result
);
   timeunit 1ns;
   timeprecision 100ps;

   // quiet state: strobes low, bus and alu data lines flip so stale values never look valid
   task automatic release_all();
      ds_rd = 1'b0;
      ds_wr = 1'b0;
      alu_acc_we = 1'b0;
      flag_c_we = 1'b0;
      flag_z_we = 1'b0;
      pc_op = PC_HOLD;
      ds_addr = ~ds_addr;
      ds_wdata = ~ds_wdata;
      alu_acc_data = ~alu_acc_data;
      alu_result = ~alu_result;
   endtask

   // move to just after the next rising edge
   task automatic edge_step();
      @(posedge mclk);
      #1;
   endtask

   // one data-space cycle, optionally with an alu accumulator write beside it
   task automatic bus(input byte_t a, input byte_t d, input logic w, input logic r,
                      input logic acc, input byte_t ad);
      edge_step();
      ds_addr = a;
      ds_wdata = d;
      ds_wr = w;
      ds_rd = r;
      alu_acc_we = acc;
      alu_acc_data = ad;
      edge_step();
      release_all();
   endtask

   // one program counter command; the stack carries only pc, callers save data
   task automatic op(input pc_op_e o, input pc_t t);
      edge_step();
      pc_op = o;
      jump_target = t;
      irq_vector = t;
      rel_offset = t[7:0];
      edge_step();
      release_all();
   endtask

   // alu result: carry value and result byte for the zero flag
   task automatic flags(input logic c, input byte_t r);
      edge_step();
      flag_c_we = 1'b1;
      flag_c_in = c;
      flag_z_we = 1'b1;
      alu_result = r;
      edge_step();
      release_all();
   endtask

   // up to three commands on consecutive edges, no idle cycle between them
   task automatic op_run(input pc_op_e a, input pc_op_e b, input pc_op_e c, input pc_t t);
      edge_step();
      pc_op = a;
      jump_target = t;
      irq_vector = t;
      rel_offset = t[7:0];
      edge_step();
      pc_op = b;
      edge_step();
      pc_op = c;
      edge_step();
      release_all();
   endtask

   // alu result written while the counter steps past the instruction
   task automatic alu_step(input logic c, input byte_t r);
      edge_step();
      pc_op = PC_INC;
      flag_c_we = 1'b1;
      flag_c_in = c;
      flag_z_we = 1'b1;
      alu_result = r;
      edge_step();
      release_all();
   endtask

   // write then read of one location on consecutive edges
   task automatic wr_rd(input byte_t a, input byte_t d);
      edge_step();
      ds_addr = a;
      ds_wdata = d;
      ds_wr = 1'b1;
      edge_step();
      ds_wr = 1'b0;
      ds_rd = 1'b1;
      edge_step();
      release_all();
   endtask

   // defined values from time zero
   initial begin
      ds_addr = 8'h00;
      ds_wdata = 8'h00;
      alu_acc_data = 8'h00;
      alu_result = 8'h00;
      jump_target = 12'h000;
      rel_offset = 8'h00;
      irq_vector = 12'h000;
      flag_c_in = 1'b0;
      release_all();
   end
endmodule

//--- verification/tb.sv
// self-checking bench for the core register, flag and stack block
module tb
   import cpu_core_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk;
   logic resetn;
   byte_t ds_addr, ds_wdata, alu_acc_data, rel_offset, alu_result, ds_rdata;
   byte_t accumulator, pointer_reg_one, pointer_reg_two;
   byte_t short_direct_reg_one, short_direct_reg_two;
   logic ds_rd, ds_wr, alu_acc_we, flag_c_we, flag_c_in, flag_z_we;
   logic ds_hit, carry_flag, zero_flag;
   pc_op_e pc_op;
   pc_t jump_target, irq_vector, pc;
   ctx_e ctx_now;
   int error_cnt = 0;
   int checked = 0;

   sequencer_model sq (.mclk, .ds_addr, .ds_rd, .ds_wr, .ds_wdata, .alu_acc_we,
      .alu_acc_data, .pc_op, .jump_target, .rel_offset, .irq_vector, .flag_c_we,
      .flag_c_in, .flag_z_we, .alu_result);

   cpu_core_regs_flags_stack u_dut (.mclk, .resetn, .ds_addr, .ds_rd, .ds_wr,
      .ds_wdata, .ds_rdata, .ds_hit, .alu_acc_we, .alu_acc_data, .pc_op,
      .jump_target, .rel_offset, .irq_vector, .flag_c_we, .flag_c_in, .flag_z_we,
      .alu_result, .accumulator, .pointer_reg_one, .pointer_reg_two,
      .short_direct_reg_one, .short_direct_reg_two, .pc, .carry_flag, .zero_flag,
      .flag_context(ctx_now));

   // compare one value, count and report
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // counts, verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // reset state, then context switching with nested interrupts
   task automatic test_flags();
      check("pc", pc, 12'hffe);
      check("ctx", ctx_now, CTX_NMI);
      check("carry", carry_flag, 1'b0);
      check("acc", accumulator, 8'h00);
      sq.op(PC_INTERRUPT_RETURN_INSTR, 12'h000);
      check("ctx", ctx_now, CTX_NORMAL);
      check("pc", pc, 12'hfff);
      sq.flags(1'b1, 8'h00);
      check("carry", carry_flag, 1'b1);
      check("zero", zero_flag, 1'b1);
      sq.op(PC_IRQ, 12'h0f0);
      check("ctx", ctx_now, CTX_IRQ);
      check("pc", pc, 12'h0f0);
      check("carry", carry_flag, 1'b0);
      sq.flags(1'b1, 8'h5a);
      check("zero", zero_flag, 1'b0);
      sq.op(PC_NMI, 12'h000);
      check("ctx", ctx_now, CTX_NMI);
      check("pc", pc, 12'hffc);
      check("carry", carry_flag, 1'b0);
      sq.op(PC_INTERRUPT_RETURN_INSTR, 12'h000);
      check("ctx", ctx_now, CTX_IRQ);
      check("pc", pc, 12'h0f0);
      check("carry", carry_flag, 1'b1);
      check("zero", zero_flag, 1'b0);
      sq.op(PC_INTERRUPT_RETURN_INSTR, 12'h000);
      check("ctx", ctx_now, CTX_NORMAL);
      check("pc", pc, 12'hfff);
      check("zero", zero_flag, 1'b1);
      $display("test flags done");
   endtask

   // mapped registers, unmapped places, read during write, alu path
   task automatic test_regs();
      byte_t addrs[5] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff};
      for (int i = 0; i < 5; i++) begin
         sq.bus(addrs[i], 8'ha0 + byte_t'(i), 1'b1, 1'b0, 1'b0, 8'h00);
         sq.bus(addrs[i], 8'h00, 1'b0, 1'b1, 1'b0, 8'h00);
         check("rdata", ds_rdata, 8'ha0 + byte_t'(i));
         check("hit", ds_hit, 1'b1);
      end
      sq.edge_step();
      check("rdata idle", ds_rdata, 8'h00);
      sq.bus(8'h84, 8'hee, 1'b1, 1'b0, 1'b0, 8'h00);
      sq.bus(8'h84, 8'h00, 1'b0, 1'b1, 1'b0, 8'h00);
      check("unmapped hit", ds_hit, 1'b0);
      check("unmapped rdata", ds_rdata, 8'h00);
      check("ptr1", pointer_reg_one, 8'ha0);
      check("ptr2", pointer_reg_two, 8'ha1);
      check("sd2", short_direct_reg_two, 8'ha3);
      sq.bus(8'h82, 8'h55, 1'b1, 1'b1, 1'b0, 8'h00);
      check("rdata old", ds_rdata, 8'ha2);
      check("sd1", short_direct_reg_one, 8'h55);
      sq.bus(8'h80, 8'h00, 1'b0, 1'b0, 1'b1, 8'h3c);
      check("acc alu", accumulator, 8'h3c);
      sq.bus(8'hff, 8'hc3, 1'b1, 1'b0, 1'b1, 8'h99);
      check("acc bus", accumulator, 8'hc3);
      sq.wr_rd(8'h82, 8'h6b);
      check("sd1 rd", ds_rdata, 8'h6b);
      check("sd1 hit", ds_hit, 1'b1);
      $display("test regs done");
   endtask

   // program counter sources, signed offsets and wrap
   task automatic test_pc();
      sq.op(PC_JUMP, 12'h7f0);
      check("pc jump", pc, 12'h7f0);
      sq.op(PC_INC, 12'h000);
      check("pc inc", pc, 12'h7f1);
      sq.op(PC_REL, 12'h005);
      check("pc fwd", pc, 12'h7f6);
      sq.op(PC_REL, 12'h0f0);
      check("pc back", pc, 12'h7e6);
      sq.op(PC_HOLD, 12'h000);
      check("pc hold", pc, 12'h7e6);
      sq.op(PC_JUMP, 12'hfff);
      sq.op(PC_INC, 12'h000);
      check("pc wrap", pc, 12'h000);
      sq.alu_step(1'b0, 8'h01);
      check("pc alu", pc, 12'h001);
      check("carry alu", carry_flag, 1'b0);
      check("zero alu", zero_flag, 1'b0);
      $display("test pc done");
   endtask

   // seven nested calls, six returns, one return on an empty stack
   task automatic test_stack();
      sq.op(PC_JUMP, 12'h010);
      for (int i = 1; i <= 7; i++) begin
         sq.op(PC_CALL, 12'h100 + pc_t'(i));
         check("pc call", pc, 12'h100 + pc_t'(i));
      end
      for (int i = 6; i >= 1; i--) begin
         sq.op(PC_RET, 12'h000);
         check("pc ret", pc, 12'h100 + pc_t'(i));
      end
      sq.op(PC_RET, 12'h000);
      check("pc empty ret", pc, 12'h102);
      check("ctx", ctx_now, CTX_NORMAL);
      sq.op_run(PC_IRQ, PC_NMI, PC_INTERRUPT_RETURN_INSTR, 12'h0e0);
      check("ctx nest", ctx_now, CTX_IRQ);
      check("pc nest", pc, 12'h0e0);
      sq.op_run(PC_CALL, PC_RET, PC_INTERRUPT_RETURN_INSTR, 12'h345);
      check("ctx back", ctx_now, CTX_NORMAL);
      check("pc back", pc, 12'h102);
      sq.op_run(PC_IRQ, PC_INTERRUPT_RETURN_INSTR, PC_HOLD, 12'h0e0);
      check("ctx quick", ctx_now, CTX_NORMAL);
      check("pc quick", pc, 12'h102);
      check("carry kept", carry_flag, 1'b0);
      $display("test stack done");
   endtask

   // core clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // reset, then the tests in order
   initial begin
      resetn = 1'b0;
      repeat (16) @(posedge mclk);
      #1;
      resetn = 1'b1;
      test_flags();
      test_regs();
      test_pc();
      test_stack();
      summarize();
   end

   // hang guard, far beyond the hundred or so cycles the tests need
   initial begin
      #300000;
      error_cnt++;
      summarize();
   end
endmodule
